// ===== cbpwm_ctrl.sv
// Cell-balance discharge control: reset effects, watchdog, timer, PWM.
// Assumes a register master on sys_clk and async pins for power,
// thermal shutdown and the timer enable strap.
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "cbpwm_map.svh"
module cbpwm_ctrl
    import cbpwm_pkg::*;
#(
    parameter int WDOG_CYC = `CBPWM_WDOG_CYC,
    parameter int TICK_CYC = `CBPWM_TICK_CYC,
    parameter int HALF_MIN_TICKS = `CBPWM_TICKS_PER_HALF_MIN,
    parameter int CELLS = 12
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic powerCycle,
    input wire logic thermalShutdown,
    input wire logic discharge_timer_enable_pin,
    output logic [11:0] dischargeOut,
    output logic watchdog_output_pin
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pinMeta_reg, pinSync_reg;
    logic thermPrev_reg;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pinMeta_reg <= 3'h0;
            pinSync_reg <= 3'h0;
            thermPrev_reg <= 1'b0;
        end else begin
            pinMeta_reg <= {discharge_timer_enable_pin, thermalShutdown,
                            powerCycle};
            pinSync_reg <= pinMeta_reg;
            thermPrev_reg <= pinSync_reg[1];
        end
    end
    logic pwrEvt, thermEvt, timerEn;
    assign pwrEvt = pinSync_reg[0];
    assign thermEvt = pinSync_reg[1] & ~thermPrev_reg;
    assign timerEn = pinSync_reg[2];

    cbpwm_tick_if tbus();
    cbpwm_timebase #(.TICK_CYC(TICK_CYC)) u_tb (
        .sys_clk(sys_clk),
        .rst(rst),
        .tb(tbus)
    );

    // Timeout code to length in half-minute units
    function automatic logic [7:0] dctoHalfMins(input logic [3:0] code);
        case (code)
            4'h1: dctoHalfMins = 8'h01;
            4'h2: dctoHalfMins = 8'h02;
            4'h3: dctoHalfMins = 8'h04;
            4'h4: dctoHalfMins = 8'h06;
            4'h5: dctoHalfMins = 8'h08;
            4'h6: dctoHalfMins = 8'h0A;
            4'h7: dctoHalfMins = 8'h14;
            4'h8: dctoHalfMins = 8'h1E;
            4'h9: dctoHalfMins = 8'h28;
            4'hA: dctoHalfMins = 8'h3C;
            4'hB: dctoHalfMins = 8'h50;
            4'hC: dctoHalfMins = 8'h78;
            4'hD: dctoHalfMins = 8'h96;
            4'hE: dctoHalfMins = 8'hB4;
            4'hF: dctoHalfMins = 8'hF0;
            default: dctoHalfMins = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [47:0] cfg_reg, cfg_next;
    logic [47:0] duty_reg, duty_next;
    logic [31:0] ovr_reg, ovr_next;
    logic [47:0] mpb_reg, mpb_next;
    cbpwm_state_t st_reg, st_next;
    logic wdExp_reg, wdExp_next;
    logic [31:0] wdCnt_reg, wdCnt_next;
    logic [7:0] dtHalf_reg, dtHalf_next;
    logic [8:0] dtTick_reg, dtTick_next;
    logic dtRun_reg, dtRun_next;
    logic [1:0] evt_reg, evt_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [11:0] out_reg, out_next;

    logic cmdValid, cmdWrCfg, cmdWake, wdFire, dtFire;
    logic [11:0] dcc;
    assign cmdValid = regWr && regAddr == `CBPWM_OFF_CMD &&
                      regWdata[`CBPWM_CMD_VALID];
    assign cmdWrCfg = cmdValid && regWdata[`CBPWM_CMD_WRCFG];
    assign cmdWake = regWr && regAddr == `CBPWM_OFF_CMD &&
                     regWdata[`CBPWM_CMD_WAKE];
    assign dcc = cfg_reg[`CBPWM_DCC_LSB +: 12];

    assign wdFire = !wdExp_reg && wdCnt_reg == 32'(WDOG_CYC - 1) &&
                    !cmdValid;
    assign dtFire = dtRun_reg && tbus.tick && dtHalf_reg == 8'h01 &&
                    dtTick_reg == 9'(HALF_MIN_TICKS - 1);

    // ------------------------------------------------------------
    // Next-state logic: registers, timers and reset effects
    // ------------------------------------------------------------
    always_comb begin
        cfg_next = cfg_reg;
        duty_next = duty_reg;
        ovr_next = ovr_reg;
        mpb_next = mpb_reg;
        st_next = st_reg;
        wdExp_next = wdExp_reg;
        wdCnt_next = wdCnt_reg;
        dtHalf_next = dtHalf_reg;
        dtTick_next = dtTick_reg;
        dtRun_next = dtRun_reg;
        evt_next = evt_reg;

        // Register writes
        if (regWr) begin
            case (regAddr)
                `CBPWM_OFF_DUTY_LO: duty_next[31:0] = regWdata;
                `CBPWM_OFF_DUTY_HI: duty_next[47:32] = regWdata[15:0];
                `CBPWM_OFF_OVR: ovr_next = regWdata;
                `CBPWM_OFF_MPB_LO: mpb_next[31:0] = regWdata;
                `CBPWM_OFF_MPB_HI: mpb_next[47:32] = regWdata[15:0];
                `CBPWM_OFF_CFG: cfg_next[31:0] = regWdata;
                `CBPWM_OFF_CMD: begin
                    // Command word high half carries config bytes 4-5
                    if (cmdWrCfg) begin
                        cfg_next[47:32] = regWdata[31:16];
                    end
                end
                default: ;
            endcase
        end

        // Watchdog count; any valid command restarts it
        if (cmdValid || cmdWake) begin
            wdCnt_next = 32'h00000000;
            wdExp_next = 1'b0;
            if (st_reg != CBPWM_STANDBY) begin
                st_next = CBPWM_STANDBY;
            end
        end else if (!wdExp_reg) begin
            wdCnt_next = wdCnt_reg + 32'h00000001;
        end

        // Discharge timer countdown on the shared tick
        if (dtRun_reg && tbus.tick) begin
            if (dtTick_reg == 9'(HALF_MIN_TICKS - 1)) begin
                dtTick_next = 9'h000;
                dtHalf_next = dtHalf_reg - 8'h01;
            end else begin
                dtTick_next = dtTick_reg + 9'h001;
            end
        end
        if (dtFire) begin
            dtRun_next = 1'b0;
        end

        // needs pin high and code nonzero
        if (cmdWrCfg) begin
            dtTick_next = 9'h000;
            dtHalf_next = dctoHalfMins(regWdata[31:28]);
            dtRun_next = timerEn && regWdata[31:28] != 4'h0;
        end
        if (!timerEn) begin
            dtRun_next = 1'b0;
        end

        if (wdFire) begin
            wdExp_next = 1'b1;
            if (dtRun_reg && !dtFire) begin
                st_next = CBPWM_TIMED;
                cfg_next = cfg_next & `CBPWM_CFG_HIGH_MASK;
                mpb_next = `CBPWM_MPB_RST;
            end
        end

        if (dtFire && !wdExp_reg && !wdFire) begin
            duty_next = `CBPWM_DUTY_RST;
            ovr_next = `CBPWM_OVR_RST;
            cfg_next = cmdWrCfg ? cfg_next : cfg_next & `CBPWM_CFG_LOW_MASK;
        end

        // sleep entry on bare watchdog expiry
        // or timer end after watchdog expiry
        // duty back to all ones on sleep
        if ((wdFire && !(dtRun_reg && !dtFire)) ||
            (dtFire && (wdExp_reg || wdFire))) begin
            st_next = CBPWM_SLEEP;
            wdExp_next = 1'b1;
            dtRun_next = 1'b0;
            dtHalf_next = 8'h00;
            dtTick_next = 9'h000;
            cfg_next = `CBPWM_CFG_RST;
            duty_next = `CBPWM_DUTY_RST;
            ovr_next = `CBPWM_OVR_RST;
            mpb_next = `CBPWM_MPB_RST;
        end

        // thermal trip keeps the override group
        if (thermEvt) begin
            cfg_next = `CBPWM_CFG_RST;
            mpb_next = `CBPWM_MPB_RST;
            dtRun_next = 1'b0;
        end

        // Sticky event flags; set wins over a write-one clear
        if (regWr && regAddr == `CBPWM_OFF_EVT) begin
            evt_next = evt_reg & ~regWdata[1:0];
        end
        if (thermEvt) begin
            evt_next[`CBPWM_EVT_THERMAL] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Read data, returned in the cycle after the strobe
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = 32'h00000000;
        if (regRd) begin
            case (regAddr)
                `CBPWM_OFF_CFG: rdata_next = cfg_reg[31:0];
                `CBPWM_OFF_DUTY_LO: rdata_next = duty_reg[31:0];
                `CBPWM_OFF_DUTY_HI: rdata_next = {16'h0000, duty_reg[47:32]};
                `CBPWM_OFF_OVR: rdata_next = ovr_reg;
                `CBPWM_OFF_MPB_LO: rdata_next = mpb_reg[31:0];
                `CBPWM_OFF_MPB_HI: rdata_next = {16'h0000, mpb_reg[47:32]};
                `CBPWM_OFF_CMD: rdata_next = {cfg_reg[47:32], 16'h0000};
                `CBPWM_OFF_STAT: rdata_next = {6'h00, st_reg,
                    dtHalf_reg, 3'h0, tbus.phase, dtRun_reg, wdExp_reg,
                    timerEn, 1'b0};
                `CBPWM_OFF_EVT: rdata_next = {30'h00000000, evt_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Discharge outputs
    // ------------------------------------------------------------
    always_comb begin
        logic [8:0] p;
        logic [8:0] onTicks;
        p = 9'h000;
        onTicks = 9'h000;
        out_next = 12'h000;
        for (int i = 0; i < CELLS; i++) begin
            if (tbus.phase >= 9'(i)) begin
                p = tbus.phase - 9'(i);
            end else begin
                p = tbus.phase + 9'(`CBPWM_PERIOD_TICKS - i);
            end
            // 2 s steps of a 30 s period
            onTicks = 9'(duty_reg[4*i +: 4]) * 9'(`CBPWM_STEP_TICKS);
            if (!wdExp_reg) begin
                out_next[i] = dcc[i];
            end else begin
                out_next[i] = dcc[i] && (p < onTicks);
            end
        end
        if (st_reg == CBPWM_SLEEP || thermEvt || pinSync_reg[1]) begin
            out_next = 12'h000;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // power cycle resets all but evt_reg, which takes the power event flag
    always_ff @(posedge sys_clk) begin
        if (rst || pwrEvt) begin
            cfg_reg <= `CBPWM_CFG_RST;
            duty_reg <= `CBPWM_DUTY_RST;
            ovr_reg <= `CBPWM_OVR_RST;
            mpb_reg <= `CBPWM_MPB_RST;
            st_reg <= CBPWM_STANDBY;
            wdExp_reg <= 1'b0;
            wdCnt_reg <= 32'h00000000;
            dtHalf_reg <= 8'h00;
            dtTick_reg <= 9'h000;
            dtRun_reg <= 1'b0;
            evt_reg <= rst ? 2'h0 : 2'h1;
            out_reg <= 12'h000;
            rdata_reg <= 32'h00000000;
        end else begin
            cfg_reg <= cfg_next;
            duty_reg <= duty_next;
            ovr_reg <= ovr_next;
            mpb_reg <= mpb_next;
            st_reg <= st_next;
            wdExp_reg <= wdExp_next;
            wdCnt_reg <= wdCnt_next;
            dtHalf_reg <= dtHalf_next;
            dtTick_reg <= dtTick_next;
            dtRun_reg <= dtRun_next;
            evt_reg <= evt_next;
            out_reg <= out_next;
            rdata_reg <= rdata_next;
        end
    end

    assign dischargeOut = out_reg;
    assign watchdog_output_pin = wdExp_reg;
    assign regRdata = rdata_reg;
endmodule

// ===== cbpwm_map.svh
// Constants for the cell-balance PWM and reset-effect block.
// Assumes a 100 MHz sys_clk; included by its bare name.
`ifndef CBPWM_MAP_SVH
`define CBPWM_MAP_SVH

// Register offsets on the plain register port
`define CBPWM_OFF_CFG 4'h0
`define CBPWM_OFF_DUTY_LO 4'h1
`define CBPWM_OFF_DUTY_HI 4'h2
`define CBPWM_OFF_OVR 4'h3
`define CBPWM_OFF_MPB_LO 4'h4
`define CBPWM_OFF_MPB_HI 4'h5
`define CBPWM_OFF_CMD 4'h6
`define CBPWM_OFF_STAT 4'h7
`define CBPWM_OFF_EVT 4'h8

// Configuration word layout: bytes 0..5 packed low to high
`define CBPWM_CFG_LOW_MASK 48'h0000FFFFFFFF
`define CBPWM_CFG_HIGH_MASK 48'hFFFF00000000
`define CBPWM_DCC_LSB 32
`define CBPWM_DISCHARGE_TIMEOUT_CODE_LSB 44

// Reset values
`define CBPWM_CFG_RST 48'h000000000000
`define CBPWM_DUTY_RST 48'hFFFFFFFFFFFF
`define CBPWM_OVR_RST 32'h00000000
`define CBPWM_MPB_RST 48'hFFFFFFFFFFFF

// Command register bits
`define CBPWM_CMD_VALID 0
`define CBPWM_CMD_WRCFG 1
`define CBPWM_CMD_WAKE 2

// Event register bits
`define CBPWM_EVT_POWER 0
`define CBPWM_EVT_THERMAL 1

// Timing
`define CBPWM_CLK_HZ 100000000
`define CBPWM_WDOG_MS 2000
`define CBPWM_TICK_US 62500
`define CBPWM_TICK_CYC (`CBPWM_CLK_HZ / 1000000 * `CBPWM_TICK_US)
`define CBPWM_WDOG_CYC (`CBPWM_CLK_HZ / 1000 * `CBPWM_WDOG_MS + 1)
`define CBPWM_PERIOD_TICKS 480
`define CBPWM_STEP_TICKS 32
`define CBPWM_TICKS_PER_HALF_MIN 480

`endif

// ===== cbpwm_pkg.sv
// Types for the cell-balance PWM and reset-effect block.
// Assumes nothing beyond the constants header.
package cbpwm_pkg;
    // Power states, Gray coded along standby-balance-sleep
    typedef enum logic [1:0] {
        CBPWM_STANDBY = 2'b00,
        CBPWM_TIMED = 2'b01,
        CBPWM_SLEEP = 2'b11
    } cbpwm_state_t;
endpackage

// ===== cbpwm_tick_if.sv
// Interface carrying the shared modulation time base.
// Assumes the timebase module drives it and the top reads it.
`timescale 1ns/1ps
interface cbpwm_tick_if;
    logic tick;
    logic [8:0] phase;
    modport src (output tick, output phase);
    modport dst (input tick, input phase);
endinterface

// ===== cbpwm_timebase.sv
// Free-running 62.5 ms tick and 480-tick period phase counter.
// Assumes sys_clk at 100 MHz and a synchronous active-high reset.
`timescale 1ns/1ps
`include "cbpwm_map.svh"
module cbpwm_timebase
    import cbpwm_pkg::*;
#(
    parameter int TICK_CYC = `CBPWM_TICK_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    cbpwm_tick_if.src tb
);

    logic [22:0] divCnt_reg, divCnt_next;
    logic [8:0] phase_reg, phase_next;
    logic tick_reg, tick_next;

    // ------------------------------------------------------------
    // Divider and phase
    // ------------------------------------------------------------
    // single tick base
    always_comb begin
        tick_next = 1'b0;
        divCnt_next = divCnt_reg + 23'h000001;
        phase_next = phase_reg;
        if (divCnt_reg == 23'(TICK_CYC - 1)) begin
            divCnt_next = 23'h000000;
            tick_next = 1'b1;
            if (phase_reg == 9'(`CBPWM_PERIOD_TICKS - 1)) begin
                phase_next = 9'h000;
            end else begin
                phase_next = phase_reg + 9'h001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            divCnt_reg <= 23'h000000;
            phase_reg <= 9'h000;
            tick_reg <= 1'b0;
        end else begin
            divCnt_reg <= divCnt_next;
            phase_reg <= phase_next;
            tick_reg <= tick_next;
        end
    end

    assign tb.tick = tick_reg;
    assign tb.phase = phase_reg;
endmodule

// ===== cbpwm_switch_model.sv
// Model of the external discharge switches across the twelve cells.
// Assumes the drive pins are registered on sys_clk, active high.
`timescale 1ns/1ps
module cbpwm_switch_model (
    input wire logic sys_clk,
    input wire logic [11:0] dischargeOut,
    input wire logic clearStats,
    output logic [15:0] onCount [12],
    output int riseCycle [12],
    output logic collision
);
    int cycle = 0;
    logic [11:0] prevOut = 12'h000;

    // Switch on-time, turn-on instants and simultaneous edges
    always @(posedge sys_clk) begin
        cycle <= cycle + 1;
        prevOut <= dischargeOut;
        if (clearStats) begin
            collision <= 1'b0;
        end else if ($countones(dischargeOut ^ prevOut) > 1) begin
            collision <= 1'b1;
        end
        for (int i = 0; i < 12; i++) begin
            if (clearStats) begin
                onCount[i] <= 16'h0000;
            end else if (dischargeOut[i]) begin
                onCount[i] <= onCount[i] + 16'h0001;
            end
            if (dischargeOut[i] && !prevOut[i]) begin
                riseCycle[i] <= cycle;
            end
        end
    end
endmodule

// ===== cbpwm_ctrl_asserts.sv
// Port checker for the discharge control block.
// Assumes one clock domain and the synchronous reset rst.
`timescale 1ns/1ps
module cbpwm_ctrl_chk #(
    parameter int WDOG_CYC = 50
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    input wire logic powerCycle,
    input wire logic thermalShutdown,
    input wire logic discharge_timer_enable_pin,
    input wire logic [11:0] dischargeOut,
    input wire logic watchdog_output_pin
);
    int idleCnt;
    int idleNext;
    logic [3:0] quietReg;
    logic [3:0] quietNext;
    logic validCmd;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    // ----
    // Helper logic
    // ----
    assign validCmd = regWr && regAddr == 4'h6 &&
                      (regWdata[0] || regWdata[2]);

    // Idle time since last command; saturates to stay cheap
    always_comb begin
        quietNext = {quietReg[2:0], powerCycle | thermalShutdown};
        idleNext = idleCnt;
        if (rst || powerCycle || validCmd) begin
            idleNext = 0;
        end else if (idleCnt < WDOG_CYC + 10) begin
            idleNext = idleCnt + 1;
        end
    end

    // Registers only
    always_ff @(posedge sys_clk) begin
        quietReg <= quietNext;
        idleCnt <= idleNext;
    end

    // ----
    // Sequences and assertions
    // ----
    sequence s_quiet_cfg_write;
        regWr && regAddr == 4'h6 && regWdata[1:0] == 2'b11
            && !watchdog_output_pin && quietReg == 4'h0
            && !powerCycle && !thermalShutdown;
    endsequence

    sequence s_power_held;
        powerCycle [*5];
    endsequence

    sequence s_untimed_expiry;
        (!discharge_timer_enable_pin) [*4] ##0 $rose(watchdog_output_pin);
    endsequence

    a_reset_outputs_off: assert property (
        $fell(rst) |-> dischargeOut == 12'h000 && !watchdog_output_pin)
        else $error("outputs not off after reset");
    a_power_outputs_off: assert property (
        s_power_held |-> dischargeOut == 12'h000 && !watchdog_output_pin)
        else $error("outputs not off during power cycle");
    a_thermal_outputs_off: assert property (
        thermalShutdown [*5] |-> dischargeOut == 12'h000)
        else $error("outputs not off during thermal trip");
    a_dcc_direct_drive: assert property (
        s_quiet_cfg_write |=> ##1 dischargeOut == $past(regWdata[27:16], 2))
        else $error("outputs do not follow discharge bits");
    a_wdog_not_early: assert property (
        idleCnt < WDOG_CYC - 3 |-> !watchdog_output_pin)
        else $error("watchdog expired early");
    a_wdog_expires: assert property (
        idleCnt == WDOG_CYC + 6 |-> watchdog_output_pin)
        else $error("watchdog did not expire");
    a_pwm_stagger: assert property (
        watchdog_output_pin [*4] |->
            $countones(dischargeOut ^ $past(dischargeOut)) <= 1
            || dischargeOut == 12'h000)
        else $error("two outputs switched together");
    a_sleep_outputs_off: assert property (
        s_untimed_expiry |-> ##[0:3] dischargeOut == 12'h000)
        else $error("outputs not off on sleep entry");
endmodule

bind cbpwm_ctrl cbpwm_ctrl_chk #(.WDOG_CYC(WDOG_CYC)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .powerCycle(powerCycle), .thermalShutdown(thermalShutdown),
    .discharge_timer_enable_pin(discharge_timer_enable_pin),
    .dischargeOut(dischargeOut), .watchdog_output_pin(watchdog_output_pin)
);

// ===== test_cbpwm_ctrl.sv
// Self-checking bench for the discharge control block.
// Assumes shortened counts: 10-cycle tick, 50-cycle watchdog.
`timescale 1ns/1ps
`include "cbpwm_map.svh"
module test_cbpwm_ctrl
    import cbpwm_pkg::*;
;
    localparam int W = 50;
    localparam int TK = 10;
    localparam int PER = 4800;
    localparam logic [3:0] DUTY [12] = '{4'hF, 4'h1, 4'h2, 4'h3, 4'h4,
        4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hF};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    logic powerCycle = 1'b0;
    logic thermalShutdown = 1'b0;
    logic timerPin = 1'b0;
    logic [11:0] dischargeOut;
    logic wdPin;
    logic clearStats = 1'b0;
    logic [15:0] onCount [12];
    int riseCycle [12];
    logic collision;
    logic [31:0] d;
    int errors = 0;
    int tests_run = 0;

    always #5 sys_clk = ~sys_clk;

    cbpwm_ctrl #(.WDOG_CYC(W), .TICK_CYC(TK), .HALF_MIN_TICKS(4),
        .CELLS(12)) u_dut (.sys_clk(sys_clk), .rst(rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .powerCycle(powerCycle),
        .thermalShutdown(thermalShutdown),
        .discharge_timer_enable_pin(timerPin),
        .dischargeOut(dischargeOut), .watchdog_output_pin(wdPin));

    cbpwm_switch_model u_sw (.sys_clk(sys_clk), .dischargeOut(dischargeOut),
        .clearStats(clearStats), .onCount(onCount),
        .riseCycle(riseCycle), .collision(collision));

    // ----
    // Bus tasks and checks
    // ----
    task automatic chk(input string n, input logic [31:0] e,
            input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // One-cycle write; a spare edge keeps strobes apart
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask

    task automatic rc(input logic [3:0] a, input logic [31:0] m,
            input logic [31:0] e, input string n);
        rd(a);
        chk(n, e, d & m);
    endtask

    task automatic st(input cbpwm_state_t s);
        rc(`CBPWM_OFF_STAT, 32'h03000000, {6'h0, s, 24'h0}, "state");
    endtask

    task automatic cfg(input logic [11:0] dcc, input logic [3:0] code);
        wr(`CBPWM_OFF_CMD, {code, dcc, 16'h0003});
    endtask

    // Looked at just after the edge, once the registered drive has settled
    task automatic outs(input string n, input logic [11:0] e);
        #1;
        chk(n, {20'h0, e}, {20'h0, dischargeOut});
    endtask

    task automatic conclude();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard, well beyond the longest expected run
    initial begin
        repeat (40000) @(posedge sys_clk);
        errors++;
        conclude();
    end

    // ----
    // Scenarios
    // ----
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        rc(`CBPWM_OFF_DUTY_LO, '1, 32'hFFFFFFFF, "duty lo");
        rc(`CBPWM_OFF_DUTY_HI, '1, 32'h0000FFFF, "duty hi");
        rc(`CBPWM_OFF_MPB_LO, '1, 32'hFFFFFFFF, "mpb");
        st(CBPWM_STANDBY);
        wr(4'hF, 32'h0000ABCD);
        rc(4'hF, '1, 32'h0, "unmapped");
        // Strap low: direct drive, timer stays idle
        cfg(12'hA5A, 4'hF);
        idle(2);
        outs("direct", 12'hA5A);
        rc(`CBPWM_OFF_STAT, 32'h8, 32'h0, "timer idle");
        wr(`CBPWM_OFF_OVR, 32'h00000ABC);
        wr(`CBPWM_OFF_MPB_LO, 32'h0);
        wr(`CBPWM_OFF_CFG, 32'h12345678);
        wr(`CBPWM_OFF_CMD, 32'h1);
        thermalShutdown <= 1'b1;
        idle(6);
        outs("thermal", 12'h000);
        thermalShutdown <= 1'b0;
        idle(4);
        rc(`CBPWM_OFF_CFG, '1, 32'h0, "cfg");
        rc(`CBPWM_OFF_MPB_LO, '1, 32'hFFFFFFFF, "mpb");
        rc(`CBPWM_OFF_OVR, '1, 32'h00000ABC, "ovr kept");
        rc(`CBPWM_OFF_CMD, 32'hFFFF0000, 32'h0, "cfg hi");
        rc(`CBPWM_OFF_EVT, 32'h2, 32'h2, "thermal evt");
        powerCycle <= 1'b1;
        idle(6);
        powerCycle <= 1'b0;
        idle(4);
        rc(`CBPWM_OFF_OVR, '1, 32'h0, "ovr");
        rc(`CBPWM_OFF_EVT, '1, 32'h1, "power evt");
        // Short timer expires while plain commands keep the watchdog fed
        timerPin <= 1'b1;
        idle(3);
        cfg(12'hFFF, 4'h1);
        wr(`CBPWM_OFF_CFG, 32'h00C0FFEE);
        wr(`CBPWM_OFF_DUTY_LO, 32'h0);
        wr(`CBPWM_OFF_OVR, 32'h5);
        repeat (6) begin
            idle(8);
            wr(`CBPWM_OFF_CMD, 32'h1);
        end
        outs("timer off", 12'h000);
        rc(`CBPWM_OFF_DUTY_LO, '1, 32'hFFFFFFFF, "duty");
        rc(`CBPWM_OFF_OVR, '1, 32'h0, "ovr");
        rc(`CBPWM_OFF_CMD, 32'hFFFF0000, 32'h0, "cfg hi");
        rc(`CBPWM_OFF_CFG, '1, 32'h00C0FFEE, "cfg kept");
        // Long timer, then the watchdog lapses into timed discharge
        cfg(12'hFFE, 4'hF);
        wr(`CBPWM_OFF_DUTY_LO, 32'h7654321F);
        wr(`CBPWM_OFF_DUTY_HI, 32'h0000FA98);
        wr(`CBPWM_OFF_CFG, 32'h12345678);
        wr(`CBPWM_OFF_MPB_LO, 32'h0);
        idle(W + 10);
        chk("expired", 32'h1, {31'h0, wdPin});
        st(CBPWM_TIMED);
        rc(`CBPWM_OFF_CFG, '1, 32'h0, "cfg");
        rc(`CBPWM_OFF_MPB_LO, '1, 32'hFFFFFFFF, "mpb");
        rc(`CBPWM_OFF_CMD, 32'hFFFF0000, 32'hFFFE0000, "cfg hi");
        clearStats <= 1'b1;
        idle(1);
        clearStats <= 1'b0;
        idle(PER);
        #1;
        for (int i = 0; i < 12; i++) begin
            chk("on time", (i == 0) ? 32'h0 : {28'h0, DUTY[i]} * 32'h140,
                {16'h0, onCount[i]});
        end
        chk("stagger", TK, (riseCycle[2] - riseCycle[1] + PER) % PER);
        chk("collision", 32'h0, {31'h0, collision});
        d = 32'h0;
        for (int k = 0; k < 900 && d[25:24] !== 2'b11; k++) begin
            idle(10);
            rd(`CBPWM_OFF_STAT);
        end
        st(CBPWM_SLEEP);
        outs("sleep", 12'h000);
        rc(`CBPWM_OFF_DUTY_LO, '1, 32'hFFFFFFFF, "duty");
        rc(`CBPWM_OFF_CMD, 32'hFFFF0000, 32'h0, "cfg hi");
        // Wake, then lapse with no timer
        timerPin <= 1'b0;
        wr(`CBPWM_OFF_CMD, 32'h4);
        idle(3);
        cfg(12'h00F, 4'h3);
        idle(2);
        outs("woken", 12'h00F);
        wr(`CBPWM_OFF_OVR, 32'h1);
        wr(`CBPWM_OFF_DUTY_HI, 32'h0);
        wr(`CBPWM_OFF_CFG, 32'h000000FF);
        idle(W + 10);
        st(CBPWM_SLEEP);
        outs("sleep", 12'h000);
        rc(`CBPWM_OFF_OVR, '1, 32'h0, "ovr");
        rc(`CBPWM_OFF_DUTY_HI, '1, 32'h0000FFFF, "duty");
        rc(`CBPWM_OFF_CFG, '1, 32'h0, "cfg");
        rc(`CBPWM_OFF_CMD, 32'hFFFF0000, 32'h0, "cfg hi");
        conclude();
    end
endmodule
